/* hdl/rru_unit.sv */
/*
 * Rotate unit datapath and sequencer with an Avalon-MM control slave.
 * Assumes the decoder presents one instruction at a time with all bytes,
 * the register view is stable while busy, and memory answers reads with
 * mem_ack one cycle after a read request is accepted.
 */
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rru_params.svh"

module rru_unit (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Decoder side.
  input wire rru_pkg::rru_instr_s instr,
  output logic busy,
  output logic done,
  output logic illegal,
  // Register file side.
  input wire rru_pkg::rru_regs_s regs,
  output rru_pkg::rru_wb_s wb,
  // Memory sequencer side.
  output rru_pkg::rru_mem_s mem,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    rru_pkg::rru_state_e st;
    rru_pkg::rru_op_e op;
    rru_pkg::rru_loc_e loc;
    logic [2:0] sel;
    logic [4:0] tcnt;
    logic [4:0] ttot;
    logic [15:0] addr;
    logic [7:0] opnd;
    logic [7:0] mres;
    logic done;
    logic illegal;
    rru_pkg::rru_wb_s wb;
    rru_pkg::rru_mem_s mem;
    logic enable;
    logic [7:0] last_op;
    logic [7:0] last_res;
    logic [31:0] rdata;
    logic ack;
  } rru_state_s;

  rru_state_s q;
  rru_state_s next_q;

  // Even parity of a byte: high when the count of ones is even.
  function automatic logic rru_even(input logic [7:0] v);
    rru_even = ~^v;
  endfunction : rru_even

  // Register select to value.
  // register code map
  function automatic logic [7:0] rru_reg_read(input logic [2:0] s,
                                              input rru_pkg::rru_regs_s r);
    case (s)
      3'h0: rru_reg_read = r.reg_b;
      3'h1: rru_reg_read = r.reg_c;
      3'h2: rru_reg_read = r.reg_d;
      3'h3: rru_reg_read = r.reg_e;
      3'h4: rru_reg_read = r.pointer_pair[15:8];
      3'h5: rru_reg_read = r.pointer_pair[7:0];
      3'h7: rru_reg_read = r.acc;
      default: rru_reg_read = 8'h00;
    endcase
  endfunction : rru_reg_read

  // Rotate core: returns {carry, result}.
  function automatic logic [8:0] rru_rot(input rru_pkg::rru_op_e op,
                                         input logic [7:0] v,
                                         input logic cin);
    case (op)
      rru_pkg::RRU_OP_ARLC: rru_rot = {v[7], v[6:0], v[7]};
      rru_pkg::RRU_OP_ARRC, rru_pkg::RRU_OP_RRC: rru_rot = {v[0], v[0], v[7:1]};
      rru_pkg::RRU_OP_ARR, rru_pkg::RRU_OP_RR: rru_rot = {v[0], cin, v[7:1]};
      default: rru_rot = {cin, v};
    endcase
  endfunction : rru_rot

  // Flags for a full-result rotate or nibble rotate.
  // S Z even parity
  function automatic logic [7:0] rru_szp(input logic [7:0] res,
                                         input logic c);
    logic [7:0] f;
    f = 8'h00;
    f[`RRU_FLAG_S] = res[7];
    f[`RRU_FLAG_Z] = (res == 8'h00);
    f[`RRU_FLAG_PV] = rru_even(res);
    f[`RRU_FLAG_C] = c;
    rru_szp = f;
  endfunction : rru_szp

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0] op;
    logic [8:0] rot;
    logic [7:0] fl;
    logic [7:0] nib_acc;
    op = 8'h00;
    rot = 9'h000;
    fl = 8'h00;
    nib_acc = 8'h00;
    next_q = q;
    next_q.done = 1'b0;
    next_q.illegal = 1'b0;
    next_q.wb = '0;
    next_q.ack = 1'b0;
    next_q.tcnt = q.tcnt + 5'h01;

    // Bus slave: one wait cycle, then the answer.
    if ((avs_read || avs_write) && !q.ack) begin
      next_q.ack = 1'b1;
      if (avs_write && avs_address == `RRU_ADDR_CTRL) begin
        next_q.enable = avs_writedata[`RRU_CTRL_ENABLE];
      end
      if (avs_address == `RRU_ADDR_CTRL) begin
        next_q.rdata = {31'h0, q.enable};
      end else if (avs_address == `RRU_ADDR_STATUS) begin
        next_q.rdata = {29'h0, q.illegal, q.done, q.st != rru_pkg::RRU_ST_IDLE};
      end else if (avs_address == `RRU_ADDR_OPCODE) begin
        next_q.rdata = {24'h0, q.last_op};
      end else if (avs_address == `RRU_ADDR_RESULT) begin
        next_q.rdata = {24'h0, q.last_res};
      end else begin
        next_q.rdata = 32'h0;
      end
    end

    case (q.st)
      rru_pkg::RRU_ST_IDLE: begin
        next_q.tcnt = 5'h01;
        if (instr.valid && q.enable) begin
          next_q.st = rru_pkg::RRU_ST_FETCH;
          next_q.last_op = instr.opcode;
          next_q.op = rru_pkg::RRU_OP_NONE;
          next_q.loc = rru_pkg::RRU_LOC_REG;
          next_q.sel = instr.opcode[2:0];
          next_q.addr = regs.pointer_pair;
          if (instr.prefix1 == `RRU_OP_PFX_CB) begin
            op = instr.opcode;
            if (op[7:3] == `RRU_OP_RR_HI) next_q.op = rru_pkg::RRU_OP_RR;
            if (op[7:3] == `RRU_OP_RRC_HI) next_q.op = rru_pkg::RRU_OP_RRC;
            if (op[2:0] == `RRU_REG_MEM) begin
              next_q.loc = rru_pkg::RRU_LOC_PTR;
              next_q.ttot = `RRU_T_MEM;
            end else begin
              next_q.ttot = `RRU_T_REG;
            end
          end else if ((instr.prefix1 == `RRU_OP_PFX_IDX1 ||
                        instr.prefix1 == `RRU_OP_PFX_IDX2) &&
                       instr.prefix2 == `RRU_OP_PFX_CB &&
                       instr.opcode[2:0] == `RRU_REG_MEM) begin
            if (instr.opcode[7:3] == `RRU_OP_RR_HI) begin
              next_q.op = rru_pkg::RRU_OP_RR;
            end else if (instr.opcode[7:3] == `RRU_OP_RRC_HI) begin
              next_q.op = rru_pkg::RRU_OP_RRC;
            end
            if (instr.prefix1 == `RRU_OP_PFX_IDX1) begin
              next_q.loc = rru_pkg::RRU_LOC_IDX1;
              next_q.addr = regs.index_reg_first +
                            {{8{instr.disp[7]}}, instr.disp};
            end else begin
              next_q.loc = rru_pkg::RRU_LOC_IDX2;
              next_q.addr = regs.index_reg_second +
                            {{8{instr.disp[7]}}, instr.disp};
            end
            next_q.ttot = `RRU_T_IDX;
          end else if (instr.prefix1 == `RRU_OP_PFX_ED &&
                       instr.opcode == `RRU_OP_NIB_RL) begin
            next_q.op = rru_pkg::RRU_OP_NIB;
            next_q.loc = rru_pkg::RRU_LOC_PTR;
            next_q.ttot = `RRU_T_NIB;
          end else if (instr.prefix1 == `RRU_OP_NO_PFX &&
                       instr.opcode == `RRU_OP_ACC_RLC) begin
            next_q.op = rru_pkg::RRU_OP_ARLC;
            next_q.ttot = `RRU_T_ACC;
          end else if (instr.prefix1 == `RRU_OP_NO_PFX &&
                       instr.opcode == `RRU_OP_ACC_RRC) begin
            next_q.op = rru_pkg::RRU_OP_ARRC;
            next_q.ttot = `RRU_T_ACC;
          end else if (instr.prefix1 == `RRU_OP_NO_PFX &&
                       instr.opcode == `RRU_OP_ACC_RR) begin
            next_q.op = rru_pkg::RRU_OP_ARR;
            next_q.ttot = `RRU_T_ACC;
          end
          if (next_q.op == rru_pkg::RRU_OP_NONE) begin
            next_q.st = rru_pkg::RRU_ST_DONE;
            next_q.illegal = 1'b1;
            next_q.ttot = 5'h01;
          end
        end
      end
      rru_pkg::RRU_ST_FETCH: begin
        // Fetch phases of the instruction bytes are counted here.
        if (q.tcnt >= q.ttot - `RRU_T_WRITE - 5'h02 ||
            q.loc == rru_pkg::RRU_LOC_REG) begin
          if (q.loc == rru_pkg::RRU_LOC_REG) begin
            next_q.opnd = (q.op == rru_pkg::RRU_OP_RR ||
                           q.op == rru_pkg::RRU_OP_RRC) ?
                          rru_reg_read(q.sel, regs) : regs.acc;
            next_q.st = rru_pkg::RRU_ST_CALC;
          end else begin
            next_q.mem.rd = 1'b1;
            next_q.mem.addr = q.addr;
            next_q.st = rru_pkg::RRU_ST_READ;
          end
        end
      end
      rru_pkg::RRU_ST_READ: begin
        if (mem_ack) begin
          next_q.mem.rd = 1'b0;
          next_q.opnd = mem_rdata;
          next_q.st = rru_pkg::RRU_ST_CALC;
        end
      end
      rru_pkg::RRU_ST_CALC: begin
        // Internal states run until the write phase or the end.
        rot = rru_rot(q.op, q.opnd, regs.flags[`RRU_FLAG_C]);
        if (q.op == rru_pkg::RRU_OP_NIB) begin
          // memory low to high, A low to memory low
          next_q.mres = {q.opnd[3:0], regs.acc[3:0]};
        end else begin
          next_q.mres = rot[7:0];
        end
        if (q.loc == rru_pkg::RRU_LOC_REG && q.tcnt >= q.ttot) begin
          next_q.st = rru_pkg::RRU_ST_DONE;
        end else if (q.loc != rru_pkg::RRU_LOC_REG &&
                     q.tcnt >= q.ttot - `RRU_T_WRITE) begin
          next_q.mem.wr = 1'b1;
          next_q.mem.addr = q.addr;
          next_q.mem.wdata = next_q.mres;
          next_q.st = rru_pkg::RRU_ST_WRITE;
        end
      end
      rru_pkg::RRU_ST_WRITE: begin
        // write back to the same address
        if (q.tcnt >= q.ttot) begin
          next_q.mem.wr = 1'b0;
          next_q.st = rru_pkg::RRU_ST_DONE;
        end
      end
      default: begin
        next_q.st = rru_pkg::RRU_ST_IDLE;
      end
    endcase

    // Commit results as the operation finishes.
    if (next_q.st == rru_pkg::RRU_ST_DONE && q.st != rru_pkg::RRU_ST_DONE &&
        !next_q.illegal) begin
      next_q.done = 1'b1;
      rot = rru_rot(q.op, q.opnd, regs.flags[`RRU_FLAG_C]);
      next_q.wb.flags_we = 1'b1;
      if (q.op == rru_pkg::RRU_OP_NIB) begin
        // A high kept, A low from old memory high
        nib_acc = {regs.acc[7:4], q.opnd[7:4]};
        next_q.wb.acc_we = 1'b1;
        next_q.wb.acc = nib_acc;
        // flags from new A, carry kept
        next_q.wb.flags = rru_szp(nib_acc, regs.flags[`RRU_FLAG_C]);
        next_q.last_res = nib_acc;
      end else if (q.op == rru_pkg::RRU_OP_ARLC ||
                   q.op == rru_pkg::RRU_OP_ARRC ||
                   q.op == rru_pkg::RRU_OP_ARR) begin
        // keep S Z PV, clear H N
        fl = regs.flags;
        fl[`RRU_FLAG_H] = 1'b0;
        fl[`RRU_FLAG_N] = 1'b0;
        fl[`RRU_FLAG_C] = rot[8];
        next_q.wb.flags = fl;
        next_q.wb.acc_we = 1'b1;
        next_q.wb.acc = rot[7:0];
        next_q.last_res = rot[7:0];
      end else begin
        next_q.wb.flags = rru_szp(rot[7:0], rot[8]);
        next_q.last_res = rot[7:0];
        if (q.loc == rru_pkg::RRU_LOC_REG) begin
          next_q.wb.reg_we = 1'b1;
          next_q.wb.reg_sel = q.sel;
          next_q.wb.reg_val = rot[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.enable <= `RRU_RST_CTRL;
    end else begin
      q <= next_q;
    end
  end

  // Outputs.
  assign busy = (q.st != rru_pkg::RRU_ST_IDLE);
  assign done = q.done;
  assign illegal = q.illegal;
  assign wb = q.wb;
  assign mem = q.mem;
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !q.ack;

endmodule : rru_unit
`default_nettype wire

/* hdl/rru_params.svh */
/*
 * Constants for the rotate unit: opcodes, register codes, flag bit
 * positions, state counts, register offsets and reset values.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef RRU_PARAMS_SVH
`define RRU_PARAMS_SVH

// ----------------------------------------------------------------------
// Opcode bytes
// ----------------------------------------------------------------------
`define RRU_OP_ACC_RLC 8'h07
`define RRU_OP_ACC_RRC 8'h0F
`define RRU_OP_ACC_RR 8'h1F
`define RRU_OP_PFX_CB 8'hCB
`define RRU_OP_PFX_ED 8'hED
`define RRU_OP_PFX_IDX1 8'hDD
`define RRU_OP_PFX_IDX2 8'hFD
`define RRU_OP_NIB_RL 8'h6F
`define RRU_OP_RRC_HI 5'h01
`define RRU_OP_RR_HI 5'h03
`define RRU_REG_MEM 3'h6
`define RRU_OP_NO_PFX 8'h00

// ----------------------------------------------------------------------
// Flag bit positions within the flag register
// ----------------------------------------------------------------------
`define RRU_FLAG_C 0
`define RRU_FLAG_N 1
`define RRU_FLAG_PV 2
`define RRU_FLAG_H 4
`define RRU_FLAG_Z 6
`define RRU_FLAG_S 7

// ----------------------------------------------------------------------
// Clock-state totals per form
// ----------------------------------------------------------------------
`define RRU_T_ACC 5'h03
`define RRU_T_REG 5'h07
`define RRU_T_MEM 5'h0D
`define RRU_T_IDX 5'h13
`define RRU_T_NIB 5'h10
`define RRU_T_WRITE 5'h03

// ----------------------------------------------------------------------
// Register map (word offsets are byte addresses)
// ----------------------------------------------------------------------
`define RRU_ADDR_CTRL 4'h0
`define RRU_ADDR_STATUS 4'h4
`define RRU_ADDR_OPCODE 4'h8
`define RRU_ADDR_RESULT 4'hC
`define RRU_CTRL_ENABLE 0
`define RRU_RST_CTRL 1'b1
`define RRU_RST_BYTE 8'h00

`endif

/* hdl/rru_pkg.sv */
/*
 * Types shared by the rotate unit: operation codes, states, and the
 * request and answer carriers toward the decoder and memory sequencer.
 * Assumes the params header is on the include path.
 */
`default_nettype none

package rru_pkg;

  // Operation selected by the decoder.
  typedef enum logic [2:0] {
    RRU_OP_NONE = 3'b000,
    RRU_OP_ARLC = 3'b001,
    RRU_OP_ARRC = 3'b010,
    RRU_OP_ARR = 3'b011,
    RRU_OP_RRC = 3'b100,
    RRU_OP_RR = 3'b101,
    RRU_OP_NIB = 3'b110
  } rru_op_e;

  // Operand location.
  typedef enum logic [1:0] {
    RRU_LOC_REG = 2'b00,
    RRU_LOC_PTR = 2'b01,
    RRU_LOC_IDX1 = 2'b10,
    RRU_LOC_IDX2 = 2'b11
  } rru_loc_e;

  // Sequencer states.
  typedef enum logic [2:0] {
    RRU_ST_IDLE = 3'b000,
    RRU_ST_FETCH = 3'b001,
    RRU_ST_READ = 3'b010,
    RRU_ST_CALC = 3'b011,
    RRU_ST_WRITE = 3'b100,
    RRU_ST_DONE = 3'b101
  } rru_state_e;

  // Instruction bytes from the decoder.
  typedef struct packed {
    logic valid;
    logic [7:0] prefix1;
    logic [7:0] prefix2;
    logic [7:0] disp;
    logic [7:0] opcode;
  } rru_instr_s;

  // Architectural view of the core registers.
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
    logic [15:0] pointer_pair;
    logic [15:0] index_reg_first;
    logic [15:0] index_reg_second;
    logic [7:0] reg_b;
    logic [7:0] reg_c;
    logic [7:0] reg_d;
    logic [7:0] reg_e;
  } rru_regs_s;

  // Memory request toward the sequencer.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } rru_mem_s;

  // Register file write-back.
  typedef struct packed {
    logic acc_we;
    logic [7:0] acc;
    logic flags_we;
    logic [7:0] flags;
    logic reg_we;
    logic [2:0] reg_sel;
    logic [7:0] reg_val;
  } rru_wb_s;

endpackage : rru_pkg
`default_nettype wire

/* verif/rru_unit_sva.sv */
/* Checker for the rotate unit: results, flags and memory addresses.
   Assumes a bind to rru_unit and a register view held while busy. */
`timescale 1ns/1ps
`default_nettype none

module rru_unit_chk (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Watched ports.
  input wire rru_pkg::rru_instr_s instr,
  input wire logic busy,
  input wire logic done,
  input wire rru_pkg::rru_regs_s regs,
  input wire rru_pkg::rru_wb_s wb,
  input wire rru_pkg::rru_mem_s mem,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  rru_pkg::rru_instr_s op_q;
  logic [7:0] rd_q;
  logic [7:0] wd_q;
  logic acc_q;
  logic mem_q;

  // Keep the accepted instruction and the bytes read and written.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      op_q <= '0;
      rd_q <= 8'h00;
      wd_q <= 8'h00;
    end else begin
      if (instr.valid && !busy) op_q <= instr;
      if (mem_ack) rd_q <= mem_rdata;
      if (mem.wr) wd_q <= mem.wdata;
    end
  end

  // Completion of an accumulator form and of a memory operand form.
  assign acc_q = done && op_q.prefix1 == 8'h00;
  assign mem_q = done && wb.flags_we && op_q.opcode[2:0] == 3'h6 &&
                 (op_q.prefix1 == 8'hCB || op_q.prefix2 == 8'hCB);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // left circular result.
  acc_rlc_a: assert property (
    acc_q && op_q.opcode == 8'h07 |-> wb.acc == {regs.acc[6:0],
    regs.acc[7]} && wb.flags[0] == regs.acc[7]) else $error("rlc bad");
  acc_rrc_a: assert property (
    acc_q && op_q.opcode == 8'h0F |-> wb.acc == {regs.acc[0],
    regs.acc[7:1]} && wb.flags[0] == regs.acc[0]) else $error("rrc bad");
  acc_rr_a: assert property (
    acc_q && op_q.opcode == 8'h1F |-> wb.acc == {regs.flags[0],
    regs.acc[7:1]} && wb.flags[0] == regs.acc[0]) else $error("rr bad");
  acc_flags_a: assert property (
    acc_q && wb.flags_we |-> wb.flags[7:6] == regs.flags[7:6] &&
    wb.flags[2] == regs.flags[2] && !wb.flags[4] && !wb.flags[1])
    else $error("accumulator flags bad");
  nib_acc_a: assert property (
    done && op_q.prefix1 == 8'hED && op_q.opcode == 8'h6F |->
    wb.acc == {regs.acc[7:4], rd_q[7:4]} && wb.flags[0] == regs.flags[0])
    else $error("nibble accumulator bad");
  ptr_addr_a: assert property (
    (mem.rd || mem.wr) && op_q.prefix1 inside {8'hCB, 8'hED} |->
    mem.addr == regs.pointer_pair) else $error("pointer address bad");
  idx_addr_a: assert property (
    (mem.rd || mem.wr) && op_q.prefix1 == 8'hDD |-> mem.addr ==
    regs.index_reg_first + {{8{op_q.disp[7]}}, op_q.disp})
    else $error("indexed address bad");
  mem_flags_a: assert property (
    mem_q |-> wb.flags[7] == wd_q[7] && wb.flags[6] == (wd_q == 8'h00)
    && wb.flags[2] == ~^wd_q) else $error("memory flags bad");
endmodule : rru_unit_chk

bind rru_unit rru_unit_chk chk_i (.core_clk(core_clk), .rst_b(rst_b),
  .instr(instr), .busy(busy), .done(done), .regs(regs), .wb(wb),
  .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

`default_nettype wire

/* verif/test_rotate_right_and_digit_rotate_unit.sv */
/* Self-checking bench for the rotate unit: bus access and op runs.
   Assumes the package, the unit and its checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none

module test_rotate_right_and_digit_rotate_unit;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk;
  logic rst_b;
  rru_pkg::rru_instr_s instr;
  rru_pkg::rru_regs_s regs;
  rru_pkg::rru_wb_s wb;
  rru_pkg::rru_wb_s cap;
  rru_pkg::rru_mem_s mem;
  logic busy, done, illegal, mem_ack, ill, rdq, avs_read, avs_write;
  logic avs_waitrequest;
  logic [7:0] mem_rdata, wdat, v, e;
  logic [15:0] waddr, raddr;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  int miscompares, n_checks, ncyc;
  logic [7:0] rv [8] = '{8'h01, 8'h31, 8'h00, 8'h02, 8'hA5, 8'h5A, 8'h00,
                         8'hFF};
  logic [7:0] aop [3] = '{8'h07, 8'h0F, 8'h1F};
  logic [7:0] aex [3] = '{8'h13, 8'hC4, 8'h44};

  rru_unit dut (.core_clk(core_clk), .rst_b(rst_b), .instr(instr),
    .busy(busy), .done(done), .illegal(illegal), .regs(regs), .wb(wb),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // Free running core clock.
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Print counts and verdict, then end the run.
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // One bus word; read data lands in q. The request stands until the
  // rising edge at which waitrequest is seen low; the watchdog ends a hang.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'h0) begin
      @(posedge core_clk);
    end
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : bus

  // Issue one instruction, answer reads, capture the outcome.
  task automatic op(input logic [7:0] p1, p2, dp, oc, rd);
    @(posedge core_clk);
    instr <= {1'h1, p1, p2, dp, oc};
    @(posedge core_clk);
    instr.valid <= 1'h0;
    mem_rdata <= rd;
    ncyc = 0;
    waddr = 16'h0000;
    raddr = 16'h0000;
    wdat = 8'h00;
    while (ncyc < 60) begin
      @(negedge core_clk);
      ncyc++;
      rdq = mem.rd === 1'h1;
      if (mem.wr === 1'h1) waddr = mem.addr;
      if (mem.wr === 1'h1) wdat = mem.wdata;
      if (rdq) raddr = mem.addr;
      if (done === 1'h1 || illegal === 1'h1) break;
      @(posedge core_clk);
      mem_ack <= rdq && !mem_ack;
    end
    ill = illegal;
    cap = wb;
    @(posedge core_clk);
    mem_ack <= 1'h0;
  endtask : op

  // Duration within the allowed slack.
  task automatic cyc(input int t);
    chk({31'h0, ncyc >= t - 2 && ncyc <= t + 4}, 32'h1);
  endtask : cyc

  // Expected S Z PV and C with H and N clear.
  function automatic logic [7:0] fl(input logic [7:0] x, input logic c);
    return {x[7], x == 8'h00, 3'h0, ~^x, 1'h0, c};
  endfunction : fl

  // Memory operand run with address, byte and flag checks.
  task automatic mop(input logic [7:0] p1, p2, dp, oc, rd,
                     input logic [15:0] ad, input logic [7:0] ex,
                     input logic c, input int t);
    op(p1, p2, dp, oc, rd);
    chk(raddr, ad);
    chk(waddr, ad);
    chk(wdat, ex);
    chk(cap.flags & 8'hD7, fl(ex, c));
    cyc(t);
  endtask : mop

  // Hang guard well beyond the expected run length.
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'h0;
    instr = '0;
    regs = '0;
    mem_ack = 1'h0;
    mem_rdata = 8'h00;
    avs_address = 4'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'h1;
    // Enable after reset, a hole reads zero, disabled unit stays idle.
    bus(1'h0, 4'h0, 32'h0);
    chk(q, 32'h1);
    bus(1'h1, 4'h1, 32'hFFFF_FFFF);
    bus(1'h0, 4'h1, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, 4'h0, 32'h0);
    instr <= {1'h1, 24'h0, 8'h0F};
    repeat (3) @(negedge core_clk);
    chk(busy, 1'h0);
    @(posedge core_clk);
    instr.valid <= 1'h0;
    bus(1'h1, 4'h0, 32'h1);
    $display("Test bus done");
    // Accumulator forms from 89 with S Z PV set and carry clear.
    for (int k = 0; k < 3; k++) begin
      regs.acc <= 8'h89;
      regs.flags <= 8'hC4;
      op(8'h00, 8'h00, 8'h00, aop[k], 8'h00);
      chk(cap.acc, aex[k]);
      chk(cap.flags & 8'hD7, 8'hC5);
      cyc(3);
    end
    $display("Test accumulator done");
    // Register forms of both right rotates over every register code except 6.
    for (int r = 0; r < 8; r++) begin
      if (r == 6) continue;
      regs.reg_b <= rv[0];
      regs.reg_c <= rv[1];
      regs.reg_d <= rv[2];
      regs.reg_e <= rv[3];
      regs.pointer_pair <= {rv[4], rv[5]};
      regs.acc <= rv[7];
      regs.flags <= 8'h01;
      for (int h = 1; h < 4; h += 2) begin
        v = rv[r];
        op(8'hCB, 8'h00, 8'h00, {h[4:0], r[2:0]}, 8'h00);
        e = {(h == 1) ? v[0] : 1'h1, v[7:1]};
        chk(cap.reg_sel, r);
        chk(cap.reg_val, e);
        chk(cap.flags & 8'hD7, fl(e, v[0]));
        cyc(7);
      end
    end
    $display("Test register done");
    // Memory forms at the pointer and at both index registers.
    regs.flags <= 8'h00;
    regs.pointer_pair <= 16'h4343;
    regs.index_reg_first <= 16'h1000;
    regs.index_reg_second <= 16'h2000;
    mop(8'hCB, 8'h00, 8'h00, 8'h1E, 8'hDD, 16'h4343, 8'h6E, 1'h1, 13);
    mop(8'hCB, 8'h00, 8'h00, 8'h0E, 8'h01, 16'h4343, 8'h80, 1'h1, 13);
    mop(8'hDD, 8'hCB, 8'hFE, 8'h1E, 8'h01, 16'h0FFE, 8'h00, 1'h1, 19);
    mop(8'hFD, 8'hCB, 8'h05, 8'h0E, 8'h88, 16'h2005, 8'h44, 1'h0, 19);
    $display("Test memory done");
    // Nibble rotate with carry set beforehand.
    regs.acc <= 8'h7A;
    regs.flags <= 8'h01;
    regs.pointer_pair <= 16'h5000;
    op(8'hED, 8'h00, 8'h00, 8'h6F, 8'h31);
    chk(waddr, 16'h5000);
    chk(raddr, 16'h5000);
    chk(wdat, 8'h1A);
    chk(cap.acc, 8'h73);
    chk(cap.flags & 8'hD7, fl(8'h73, 1'h1));
    cyc(16);
    bus(1'h0, 4'h8, 32'h0);
    chk(q, 32'h6F);
    bus(1'h0, 4'hC, 32'h0);
    chk(q, 32'h73);
    bus(1'h0, 4'h4, 32'h0);
    chk(q, 32'h0);
    $display("Test nibble done");
    // Forms the unit does not serve give no write-back.
    op(8'hCB, 8'h00, 8'h00, 8'h06, 8'h00);
    chk(ill, 1'h1);
    chk({cap.acc_we, cap.flags_we, cap.reg_we}, 3'h0);
    op(8'h00, 8'h00, 8'h00, 8'h17, 8'h00);
    chk(ill, 1'h1);
    $display("Test illegal done");
    stop_test();
  end
endmodule : test_rotate_right_and_digit_rotate_unit

`default_nettype wire
